// ---- rtl/sar_adc_sequencer.sv ----
// Purpose: digital sequencer around a 12-bit successive-approximation converter
// Assumes: one sys_clk_in period is half an instruction cycle; the analog macro
//          presents its 12-bit code on conv_data_in, synchronous to sys_clk_in
// Notes: result memory is not cleared by reset, its contents survive
`timescale 1ns/1ns

module sar_adc_sequencer
    import sar_adc_pkg::*;
#(
    parameter int NUM_INPUTS = 16,
    parameter int RESULT_WORDS = 16,
    parameter int RESULT_BITS = 12
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [4:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out,
    // trigger sources and rc oscillator clock
    input wire logic timer_trigger_in,
    input wire logic ext_trigger_in,
    input wire logic rc_osc_in,
    // analog macro and interrupt flag
    input wire logic [11:0] conv_data_in,
    output logic [3:0] mux_select_out,
    output logic sample_hold_out,
    output logic convert_active_out,
    output logic conv_clock_tick_out,
    output logic [15:0] pin_digital_enable_out,
    output logic converter_irq_flag_out
);

    if (NUM_INPUTS != 16 || RESULT_WORDS != 16 || RESULT_BITS != 12) begin : g_check
        $error("sequencer supports only 16 inputs, 16 words of 12 bits");
    end

    conv_control_one_t ctrl_one;
    conv_control_two_t ctrl_two;
    conv_control_three_t ctrl_three;
    input_channel_select_t chan_sel;
    logic [15:0] pin_analog_config;
    logic [15:0] scan_input_select;
    logic converter_irq_flag;
    logic [11:0] result_memory [RESULT_WORDS];

    seq_state_t state;
    logic [5:0] div_count;
    logic tad_tick;
    logic [4:0] acq_count;
    logic [3:0] conv_count;
    logic [3:0] sample_index;
    logic use_second_set;
    logic [3:0] scan_pos;
    logic [3:0] scan_channel;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [1:0] pin_level;
    logic [1:0] pin_level_d;
    logic ext_rise;
    logic rc_rise;

    logic write_one;
    logic write_two;
    logic soft_start;
    logic soft_stop;
    logic acq_end;
    logic conv_done;
    logic seq_complete;
    logic [4:0] auto_clocks;
    logic [3:0] write_index;
    logic run_next;

    assign write_one = reg_write_in && reg_addr_in == REG_CONTROL_ONE;
    assign write_two = reg_write_in && reg_addr_in == REG_CONTROL_TWO;
    assign soft_start = write_one && reg_wdata_in[1] && !ctrl_one.sample_control_bit;
    assign soft_stop = write_one && !reg_wdata_in[1];
    // enable as it stands after this edge: one write may enable and start, and a disable wins at once
    assign run_next = write_one ? reg_wdata_in[15] : ctrl_one.module_enable_bit;

    // pin inputs: three flops, a level change counts once stages two and three agree
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            pin_level <= 2'h0;
            pin_level_d <= 2'h0;
        end else begin
            sync_a <= {sync_a[1:0], ext_trigger_in};
            sync_b <= {sync_b[1:0], rc_osc_in};
            if (sync_a[1] == sync_a[2]) begin
                pin_level[0] <= sync_a[2];
            end
            if (sync_b[1] == sync_b[2]) begin
                pin_level[1] <= sync_b[2];
            end
            pin_level_d <= pin_level;
        end
    end

    assign ext_rise = pin_level[0] && !pin_level_d[0];
    assign rc_rise = pin_level[1] && !pin_level_d[1];

    // converter clock: divider of half-cycles, or the rc oscillator edge
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            div_count <= 6'h00;
        end else if (!ctrl_one.module_enable_bit || div_count == ctrl_three.clock_divide_field) begin
            div_count <= 6'h00;
        end else begin
            div_count <= div_count + 6'h01;
        end
    end

    always_comb begin
        if (!ctrl_one.module_enable_bit) begin
            tad_tick = 1'b0;
        end else if (ctrl_three.rc_clock_select) begin
            tad_tick = rc_rise;
        end else begin
            tad_tick = div_count == ctrl_three.clock_divide_field;
        end
    end

    // next scan input at or above the current position, wrapping to the lowest
    always_comb begin
        scan_channel = 4'h0;
        for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
            if (scan_input_select[i]) begin
                scan_channel = i[3:0];
            end
        end
        for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
            if (scan_input_select[i] && i[3:0] >= scan_pos) begin
                scan_channel = i[3:0];
            end
        end
    end

    assign auto_clocks = (ctrl_three.auto_sample_clocks < MIN_AUTO_CLOCKS) ? MIN_AUTO_CLOCKS
                         : ctrl_three.auto_sample_clocks;

    always_comb begin
        acq_end = 1'b0;
        if (state == ST_SAMPLE && ctrl_one.module_enable_bit) begin
            if (ctrl_one.trigger_source_field == TRIG_SOFTWARE) begin
                acq_end = soft_stop;
            end else if (ctrl_one.trigger_source_field == TRIG_AUTO) begin
                acq_end = tad_tick && acq_count + 5'h01 >= auto_clocks;
            end else if (ctrl_one.trigger_source_field == TRIG_EXTERNAL) begin
                acq_end = ext_rise;
            end else begin
                acq_end = timer_trigger_in;
            end
        end
    end

    assign conv_done = state == ST_CONVERT && ctrl_one.module_enable_bit && tad_tick
                       && conv_count == CONVERSION_PERIODS - 4'h1;
    assign seq_complete = conv_done && sample_index == ctrl_two.samples_per_irq_field;
    assign write_index = ctrl_two.buffer_split_bit ? {ctrl_two.fill_half, sample_index[2:0]}
                         : sample_index;

    // sequencer state
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
        end else if (!run_next) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (soft_start) begin
                        state <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (acq_end) begin
                        state <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (conv_done) begin
                        state <= ctrl_one.auto_sample_bit ? ST_SAMPLE : ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // acquisition and conversion period counters
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            acq_count <= 5'h00;
            conv_count <= 4'h0;
        end else begin
            if (state != ST_SAMPLE) begin
                acq_count <= 5'h00;
            end else if (tad_tick) begin
                acq_count <= acq_count + 5'h01;
            end
            if (state != ST_CONVERT) begin
                conv_count <= 4'h0;
            end else if (tad_tick) begin
                conv_count <= conv_count + 4'h1;
            end
        end
    end

    // sample position, input set alternation and scan position
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sample_index <= 4'h0;
            use_second_set <= 1'b0;
            scan_pos <= 4'h0;
        end else if (!ctrl_one.module_enable_bit) begin
            sample_index <= 4'h0;
            use_second_set <= 1'b0;
            scan_pos <= 4'h0;
        end else if (seq_complete) begin
            sample_index <= 4'h0;
            use_second_set <= 1'b0;
            scan_pos <= 4'h0;
        end else if (conv_done) begin
            sample_index <= sample_index + 4'h1;
            use_second_set <= ctrl_two.alternate_input_bit && !use_second_set;
            if (ctrl_two.scan_enable_bit && !use_second_set) begin
                scan_pos <= scan_channel + 4'h1;
            end
        end
    end

    // results go in only when a conversion runs to its end
    always_ff @(posedge sys_clk_in) begin
        if (conv_done) begin
            result_memory[write_index] <= conv_data_in;
        end
    end

    // analog-side outputs
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mux_select_out <= 4'h0;
            sample_hold_out <= 1'b0;
            convert_active_out <= 1'b0;
            conv_clock_tick_out <= 1'b0;
            pin_digital_enable_out <= ~PIN_CONFIG_RESET;
        end else begin
            if (use_second_set) begin
                mux_select_out <= chan_sel.second_input_set;
            end else if (ctrl_two.scan_enable_bit) begin
                mux_select_out <= scan_channel;
            end else begin
                mux_select_out <= chan_sel.first_input_set;
            end
            sample_hold_out <= state == ST_SAMPLE;
            convert_active_out <= state == ST_CONVERT;
            conv_clock_tick_out <= tad_tick;
            pin_digital_enable_out <= ~pin_analog_config;
        end
    end

    assign converter_irq_flag_out = converter_irq_flag;

    // control register one; hardware owns sample control and done
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctrl_one <= RESET_WORD;
        end else begin
            if (write_one) begin
                ctrl_one.module_enable_bit <= reg_wdata_in[15];
                ctrl_one.output_form <= reg_wdata_in[9:8];
                ctrl_one.trigger_source_field <= reg_wdata_in[7:5];
                ctrl_one.auto_sample_bit <= reg_wdata_in[2];
            end
            if (!run_next) begin
                ctrl_one.sample_control_bit <= 1'b0;
            end else if (conv_done && ctrl_one.auto_sample_bit) begin
                ctrl_one.sample_control_bit <= 1'b1;
            end else if (acq_end) begin
                ctrl_one.sample_control_bit <= 1'b0;
            end else if (write_one && state != ST_CONVERT) begin
                ctrl_one.sample_control_bit <= reg_wdata_in[1];
            end
            // set wins over the clear at a new start
            if (seq_complete) begin
                ctrl_one.done_flag <= 1'b1;
            end else if (soft_start) begin
                ctrl_one.done_flag <= 1'b0;
            end
        end
    end

    // control register two; the half being filled is hardware state
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctrl_two <= RESET_WORD;
        end else begin
            if (write_two) begin
                ctrl_two.scan_enable_bit <= reg_wdata_in[10];
                ctrl_two.samples_per_irq_field <= reg_wdata_in[5:2];
                ctrl_two.buffer_split_bit <= reg_wdata_in[1];
                ctrl_two.alternate_input_bit <= reg_wdata_in[0];
            end
            if (!ctrl_one.module_enable_bit) begin
                ctrl_two.fill_half <= 1'b0;
            end else if (seq_complete && ctrl_two.buffer_split_bit) begin
                ctrl_two.fill_half <= !ctrl_two.fill_half;
            end
        end
    end

    // remaining configuration registers; software keeps them still while enabled
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctrl_three <= RESET_WORD;
            chan_sel <= RESET_WORD;
            pin_analog_config <= PIN_CONFIG_RESET;
            scan_input_select <= RESET_WORD;
        end else if (reg_write_in) begin
            if (reg_addr_in == REG_CONTROL_THREE) begin
                ctrl_three.auto_sample_clocks <= reg_wdata_in[12:8];
                ctrl_three.rc_clock_select <= reg_wdata_in[7];
                ctrl_three.clock_divide_field <= reg_wdata_in[5:0];
            end else if (reg_addr_in == REG_CHANNEL_SELECT) begin
                chan_sel.second_input_set <= reg_wdata_in[11:8];
                chan_sel.first_input_set <= reg_wdata_in[3:0];
            end else if (reg_addr_in == REG_PIN_CONFIG) begin
                pin_analog_config <= reg_wdata_in;
            end else if (reg_addr_in == REG_SCAN_SELECT) begin
                scan_input_select <= reg_wdata_in;
            end
        end
    end

    // interrupt flag: software writes zero to clear, a new event wins
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            converter_irq_flag <= 1'b0;
        end else if (seq_complete) begin
            converter_irq_flag <= 1'b1;
        end else if (reg_write_in && reg_addr_in == REG_IRQ_STATUS && !reg_wdata_in[0]) begin
            converter_irq_flag <= 1'b0;
        end
    end

    // read formatting
    function automatic logic [15:0] format_result(input logic [11:0] code, input logic [1:0] form);
        logic [11:0] offset;
        offset = code ^ MIDSCALE;
        case (form)
            FORM_INTEGER: format_result = {4'h0, code};
            FORM_SIGNED_INT: format_result = {{4{offset[11]}}, offset};
            FORM_FRACTION: format_result = {code, 4'h0};
            default: format_result = {offset, 4'h0};
        endcase
    endfunction : format_result

    // read data stand one cycle after the read strobe, zero otherwise
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || !reg_read_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_addr_in[RESULT_ADDR_BIT]) begin
            reg_rdata_out <= format_result(result_memory[reg_addr_in[3:0]], ctrl_one.output_form);
        end else if (reg_addr_in == REG_CONTROL_ONE) begin
            reg_rdata_out <= ctrl_one & 16'h87e7;
        end else if (reg_addr_in == REG_CONTROL_TWO) begin
            reg_rdata_out <= ctrl_two & 16'h04bf;
        end else if (reg_addr_in == REG_CONTROL_THREE) begin
            reg_rdata_out <= ctrl_three & 16'h1fbf;
        end else if (reg_addr_in == REG_CHANNEL_SELECT) begin
            reg_rdata_out <= chan_sel & 16'h0f0f;
        end else if (reg_addr_in == REG_PIN_CONFIG) begin
            reg_rdata_out <= pin_analog_config;
        end else if (reg_addr_in == REG_SCAN_SELECT) begin
            reg_rdata_out <= scan_input_select;
        end else if (reg_addr_in == REG_IRQ_STATUS) begin
            reg_rdata_out <= {15'h0000, converter_irq_flag};
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule : sar_adc_sequencer

// ---- rtl/sar_adc_pkg.sv ----
// Purpose: shared constants and register layouts of the converter sequencer
// Assumes: 16-bit register words, word-indexed register port
// Notes: result words sit at indices RESULT_BASE..RESULT_BASE+15
package sar_adc_pkg;
    // register indices
    localparam logic [4:0] REG_CONTROL_ONE = 5'h00;
    localparam logic [4:0] REG_CONTROL_TWO = 5'h01;
    localparam logic [4:0] REG_CONTROL_THREE = 5'h02;
    localparam logic [4:0] REG_CHANNEL_SELECT = 5'h03;
    localparam logic [4:0] REG_PIN_CONFIG = 5'h04;
    localparam logic [4:0] REG_SCAN_SELECT = 5'h05;
    localparam logic [4:0] REG_IRQ_STATUS = 5'h06;
    localparam logic [4:0] RESULT_BASE = 5'h10;
    localparam int RESULT_ADDR_BIT = 4;

    // reset values
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] PIN_CONFIG_RESET = 16'h0000;

    // trigger source encodings
    localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
    localparam logic [2:0] TRIG_EXTERNAL = 3'h1;
    localparam logic [2:0] TRIG_AUTO = 3'h7;

    // output formats
    localparam logic [1:0] FORM_INTEGER = 2'h0;
    localparam logic [1:0] FORM_SIGNED_INT = 2'h1;
    localparam logic [1:0] FORM_FRACTION = 2'h2;
    localparam logic [1:0] FORM_SIGNED_FRACTION = 2'h3;

    // conversion length in converter clock periods
    localparam logic [3:0] CONVERSION_PERIODS = 4'he;
    localparam logic [11:0] MIDSCALE = 12'h800;
    localparam logic [4:0] MIN_AUTO_CLOCKS = 5'h01;

    typedef struct packed {
        logic module_enable_bit;
        logic [4:0] rsv_hi;
        logic [1:0] output_form;
        logic [2:0] trigger_source_field;
        logic [1:0] rsv_lo;
        logic auto_sample_bit;
        logic sample_control_bit;
        logic done_flag;
    } conv_control_one_t;

    typedef struct packed {
        logic [4:0] rsv_hi;
        logic scan_enable_bit;
        logic [1:0] rsv_mid;
        logic fill_half;
        logic rsv_lo;
        logic [3:0] samples_per_irq_field;
        logic buffer_split_bit;
        logic alternate_input_bit;
    } conv_control_two_t;

    typedef struct packed {
        logic [2:0] rsv_hi;
        logic [4:0] auto_sample_clocks;
        logic rc_clock_select;
        logic rsv_lo;
        logic [5:0] clock_divide_field;
    } conv_control_three_t;

    typedef struct packed {
        logic [3:0] rsv_hi;
        logic [3:0] second_input_set;
        logic [3:0] rsv_lo;
        logic [3:0] first_input_set;
    } input_channel_select_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11
    } seq_state_t;
endpackage : sar_adc_pkg

// ---- dv/analog_input_model.sv ----
// Purpose: analog pins and sample-and-hold in front of the converter
// Assumes: the code follows the selected pin while acquiring, frozen after
// Notes: rc oscillator free-runs, unrelated in phase to the system clock
`timescale 1ns/1ns
module analog_input_model (
    // converter side
    input wire logic clk_in,
    input wire logic [3:0] mux_in,
    input wire logic hold_in,
    output logic [11:0] code_out,
    output logic rc_out
);
    initial begin
        rc_out = 1'b0;
        forever #37 rc_out = ~rc_out;
    end
    // each pin carries a level that names its channel, so a wrong mux shows in the result
    always_ff @(posedge clk_in) if (hold_in) code_out <= {mux_in, ~mux_in, mux_in};
endmodule : analog_input_model

// ---- dv/sar_adc_sequencer_properties.sv ----
// Purpose: port-level assertions for the converter sequencer
// Assumes: only top-level ports visible, one clock domain
// Notes: bound to every instance of the sequencer
`timescale 1ns/1ns
module sar_adc_sequencer_properties
    import sar_adc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [4:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [15:0] reg_rdata_out,
    // converter side
    input wire logic sample_hold_out,
    input wire logic convert_active_out,
    input wire logic [15:0] pin_digital_enable_out,
    input wire logic converter_irq_flag_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence ctrl1_wr;
        reg_write_in && reg_addr_in == REG_CONTROL_ONE;
    endsequence
    sequence idle_seen;
        !sample_hold_out && !convert_active_out;
    endsequence
    rdata_idle_a: assert property (!$past(reg_read_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data without a read strobe");
    pin_follow_a: assert property ($past(reg_write_in && reg_addr_in == REG_PIN_CONFIG, 2)
        |-> pin_digital_enable_out == ~$past(reg_wdata_in, 2)) else $error("pin mode does not follow config");
    irq_clear_a: assert property (reg_write_in && reg_addr_in == REG_IRQ_STATUS && !reg_wdata_in[0]
        && !convert_active_out |=> !converter_irq_flag_out) else $error("irq flag not cleared");
    irq_cause_a: assert property ($rose(converter_irq_flag_out) |-> $past(convert_active_out)
        || $past(convert_active_out, 2) || $past(convert_active_out, 3)) else $error("irq without conversion");
    start_acq_a: assert property (ctrl1_wr ##0 idle_seen ##0 (reg_wdata_in[15] && reg_wdata_in[1])
        |-> ##2 sample_hold_out) else $error("acquisition did not start");
    abort_idle_a: assert property (ctrl1_wr ##0 !reg_wdata_in[15] |-> ##2 idle_seen[*2])
        else $error("disable did not stop sequencing");
    soft_conv_a: assert property (sample_hold_out ##0 ctrl1_wr ##0 (reg_wdata_in[15] && !reg_wdata_in[1]
        && reg_wdata_in[7:5] == TRIG_SOFTWARE) |-> ##[1:3] convert_active_out) else $error("no conversion");
    irq_read_a: assert property (reg_read_in && reg_addr_in == REG_IRQ_STATUS
        |=> reg_rdata_out[0] == $past(converter_irq_flag_out)) else $error("irq status read wrong");
endmodule : sar_adc_sequencer_properties

bind sar_adc_sequencer sar_adc_sequencer_properties u_props (.sys_clk_in, .rst_n_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .sample_hold_out, .convert_active_out,
    .pin_digital_enable_out, .converter_irq_flag_out);

// ---- dv/sar_adc_sequencer_tb.sv ----
// Purpose: self-checking bench for the converter sequencer
// Assumes: one-cycle read data, analog model on the far side
// Notes: small dividers keep conversions short; seed fixed
`timescale 1ns/1ns
module sar_adc_sequencer_tb;
    import sar_adc_pkg::*;
    logic sys_clk_in, rst_n_in, reg_write_in, reg_read_in, timer_trigger_in, ext_trigger_in, rc_osc_in;
    logic sample_hold_out, convert_active_out, conv_clock_tick_out, converter_irq_flag_out;
    logic [4:0] reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out, pin_digital_enable_out, m;
    logic [11:0] conv_data_in;
    logic [3:0] mux_select_out, a, b;
    logic [3:0] scan_ch [8];
    int bad_count, checked, n, d;

    sar_adc_sequencer dut (.*);
    analog_input_model u_analog (.clk_in(sys_clk_in), .mux_in(mux_select_out), .hold_in(sample_hold_out),
        .code_out(conv_data_in), .rc_out(rc_osc_in));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    function automatic logic [11:0] code_of(input logic [3:0] c);
        return {c, ~c, c};
    endfunction : code_of

    function automatic logic [15:0] fmt(input logic [1:0] f, input logic [11:0] c);
        logic [11:0] s;
        s = c ^ 12'h800;
        case (f)
            2'h0: return {4'h0, c};
            2'h1: return {{4{s[11]}}, s};
            2'h2: return {c, 4'h0};
            default: return {s, 4'h0};
        endcase
    endfunction : fmt

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : chk

    task automatic wr(input logic [4:0] ad, input logic [15:0] wd);
        @(posedge sys_clk_in);
        reg_addr_in <= ad;
        reg_wdata_in <= wd;
        reg_write_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_write_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] ad, input logic [15:0] exp);
        @(posedge sys_clk_in);
        reg_addr_in <= ad;
        reg_read_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_read_in <= 1'b0;
        #1 chk($sformatf("reg %h", ad), exp, reg_rdata_out);
    endtask : rd

    // let a clear written just before land first, or a stale flag ends the wait at once
    task automatic wait_irq;
        repeat (2) @(posedge sys_clk_in);
        for (int i = 0; converter_irq_flag_out !== 1'b1; i++) begin
            @(posedge sys_clk_in);
            if (i > 20000) begin
                $display("[ERR] irq flag expected 1 seen %b", converter_irq_flag_out);
                bad_count++;
                close_out();
            end
        end
    endtask : wait_irq

    initial begin
        {rst_n_in, reg_write_in, reg_read_in, timer_trigger_in, ext_trigger_in} = '0;
        reg_addr_in = '0;
        reg_wdata_in = '0;
        bad_count = 0;
        checked = 0;
        void'($urandom(37970));
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        for (int r = 0; r < 11; r++) rd(5'(r), 16'h0000);
        chk("pin mode", 16'hffff, pin_digital_enable_out);
        m = 16'($urandom);
        wr(REG_PIN_CONFIG, m);
        repeat (2) @(posedge sys_clk_in);
        #1 chk("pin mode", ~m, pin_digital_enable_out);
        $display("test registers done");
        for (int alt = 0; alt < 2; alt++) begin
            a = 4'($urandom);
            b = 4'($urandom);
            d = $urandom % 4;
            wr(REG_CONTROL_ONE, 16'h0000);
            wr(REG_CONTROL_TWO, 16'(12 + alt));
            wr(REG_CONTROL_THREE, 16'h0100 | 16'(d));
            wr(REG_CHANNEL_SELECT, {4'h0, b, 4'h0, a});
            wr(REG_CONTROL_ONE, 16'h80e6);
            n = 0;
            m = 16'h0000;
            for (int i = 0; i < 999 && convert_active_out !== 1'b1; i++) @(posedge sys_clk_in);
            while (convert_active_out === 1'b1 && n < 999) begin
                @(posedge sys_clk_in);
                n++;
                m = m + 16'(conv_clock_tick_out);
            end
            chk("conversion cycles", 16'(14 * (d + 1)), 16'(n));
            chk("converter ticks", 16'(CONVERSION_PERIODS), m);
            wait_irq();
            wr(REG_CONTROL_ONE, 16'h0000);
            rd(REG_IRQ_STATUS, 16'h0001);
            wr(REG_IRQ_STATUS, 16'h0000);
            for (int k = 0; k < 4; k++) rd(RESULT_BASE + 5'(k), {4'h0, code_of((alt && k[0]) ? b : a)});
        end
        for (int f = 0; f < 4; f++) begin
            wr(REG_CONTROL_ONE, 16'(f) << 8);
            rd(RESULT_BASE, fmt(2'(f), code_of(a)));
        end
        wr(RESULT_BASE, 16'hffff);
        rd(RESULT_BASE, fmt(2'h3, code_of(a)));
        $display("test alternate and formats done");
        m = 16'($urandom) | 16'h1111;
        n = 0;
        for (int k = 0; k < 8; k++) begin
            while (!m[n]) n = (n + 1) % 16;
            scan_ch[k] = 4'(n);
            n = (n + 1) % 16;
        end
        wr(REG_CONTROL_ONE, 16'h0000);
        wr(REG_SCAN_SELECT, m);
        wr(REG_CONTROL_TWO, 16'h041e);
        wr(REG_CONTROL_THREE, 16'h0080 | 16'(($urandom % 8 + 1) << 8));
        wr(REG_CONTROL_ONE, 16'h80e6);
        wait_irq();
        wr(REG_IRQ_STATUS, 16'h0000);
        wait_irq();
        wr(REG_CONTROL_ONE, 16'h0000);
        wr(REG_IRQ_STATUS, 16'h0000);
        for (int k = 0; k < 16; k++) rd(RESULT_BASE + 5'(k), {4'h0, code_of(scan_ch[k % 8])});
        $display("test scan and split done");
        rd(REG_CONTROL_ONE, 16'h0001);
        wr(REG_CONTROL_TWO, 16'h0000);
        wr(REG_CONTROL_THREE, 16'h0001);
        wr(REG_CONTROL_ONE, 16'h8002);
        rd(REG_CONTROL_ONE, 16'h8002);
        chk("sampling", 16'h0001, {15'h0, sample_hold_out});
        wr(REG_CONTROL_ONE, 16'h8000);
        repeat (3) @(posedge sys_clk_in);
        #1 chk("converting", 16'h0001, {15'h0, convert_active_out});
        wr(REG_CONTROL_ONE, 16'h0000);
        repeat (40) @(posedge sys_clk_in);
        rd(REG_IRQ_STATUS, 16'h0000);
        rd(RESULT_BASE, {4'h0, code_of(scan_ch[0])});
        wr(REG_CONTROL_ONE, 16'h8002);
        wr(REG_CONTROL_ONE, 16'h8000);
        wait_irq();
        rd(RESULT_BASE, {4'h0, code_of(a)});
        $display("test software trigger and abort done");
        for (int t = 1; t < 7; t++) begin
            wr(REG_CONTROL_ONE, 16'h0000);
            wr(REG_IRQ_STATUS, 16'h0000);
            wr(REG_CONTROL_ONE, 16'h8002 | 16'(t << 5));
            repeat (4) @(posedge sys_clk_in);
            timer_trigger_in <= 1'b1;
            ext_trigger_in <= 1'b1;
            @(posedge sys_clk_in);
            timer_trigger_in <= 1'b0;
            repeat (4) @(posedge sys_clk_in);
            ext_trigger_in <= 1'b0;
            wait_irq();
            rd(REG_IRQ_STATUS, 16'h0001);
        end
        $display("test other triggers done");
        close_out();
    end
endmodule : sar_adc_sequencer_tb
